// >>> rtl/dma_ti_defines.svh
`ifndef DMA_TI_DEFINES_SVH
`define DMA_TI_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_TRANSFER_INFORMATION 8'h00
`define OFS_SOURCE_ADDRESS_LOW   8'h04
`define OFS_SOURCE_ADDRESS_HIGH  8'h08
`define OFS_DEST_ADDRESS_LOW     8'h0C
`define OFS_DEST_ADDRESS_HIGH    8'h10
`define OFS_TRANSFER_LENGTH      8'h14
`define OFS_ROW_STRIDE           8'h18
`define OFS_CHANNEL_CONTROL      8'h1C
`define OFS_INT_STATUS           8'h20
`define OFS_INT_MASK             8'h24

// ---------------------------------------------------------------
// Transfer information fields
// ---------------------------------------------------------------
`define TI_WRITE_GATE      15
`define TI_READ_GATE       14
`define TI_PERIPH_MSB      13
`define TI_PERIPH_LSB      9
`define TI_READ_WAIT       3
`define TI_WRITE_WAIT      2
`define TI_TWO_DIM         1
`define TI_INT_ENABLE      0
`define TI_IMPLEMENTED     32'h0000_FE0F

// ---------------------------------------------------------------
// Length, stride, control and status fields
// ---------------------------------------------------------------
`define LEN_X_MSB          15
`define LEN_Y_MSB          29
`define LEN_Y_LSB          16
`define LEN_IMPLEMENTED    32'h3FFF_FFFF
`define STRIDE_SRC_MSB     15
`define STRIDE_DST_LSB     16
`define CTRL_ACTIVE        0
`define IRQ_DONE           0
`define IRQ_READ_ERROR     1
`define IRQ_WRITE_ERROR    2
`define IRQ_WIDTH          3

// ---------------------------------------------------------------
// Reset values and constants
// ---------------------------------------------------------------
`define RST_WORD           32'h0000_0000
`define RST_HIGH           8'h00
`define RST_IRQ            3'h0
`define RST_CNT            4'h0
`define MAX_READS_OUT      4'h4
`define MAX_WRITES_OUT     4'hF
`define QOS_NORMAL         4'h0
`define QOS_PANIC          4'hF
`define ADDR_ONE           40'h00_0000_0001

`endif

// >>> rtl/dma_ti_pkg.sv
package dma_ti_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_CLOSE = 3'b100
  } chan_state_e;

  typedef logic [39:0] byte_addr_t;
  typedef logic [29:0] row_cnt_t;
  typedef logic [13:0] rows_t;

endpackage

// >>> rtl/dma_ti_channel.sv
`timescale 1ns/1ps
`include "dma_ti_defines.svh"
// Functional notes
// [RULE_01] Five-bit select picks peripheral 1 to 31 as pacing request source.
// [RULE_02] Selected peripheral data request sets the rate of issued reads or writes.
// [RULE_03] Selected peripheral panic raises the AXI quality-of-service level.
// [RULE_04] Select value zero is a dummy request that is always active.
// [RULE_05] Read wait set: only one read outstanding, all data before next.
// [RULE_06] Read wait clear: several reads may be queued before data returns.
// [RULE_07] Write wait set: wait for write response before next write.
// [RULE_08] Write wait clear: continue once write data has been sent.
// [RULE_09] Two-dimensional mode: Y plus one rows, each of X bytes.
// [RULE_10] After each row add row stride to source and destination addresses.
// [RULE_11] Linear mode: Y and X fields together form one 30-bit byte count.
// [RULE_12] Interrupt enable set raises completion interrupt; clear raises none.
// [RULE_13] Source register holds address bits 31:0; upper bits kept separately.
// [RULE_14] Source address is byte granular, no alignment restriction.
// [RULE_15] Source register advances as reads go, showing current read address.
// [RULE_16] Request gating pauses reads or writes while selected request is low.
// [RULE_17] Row stride is a signed byte increment; negative moves backwards.
// [RULE_18] Reserved transfer-information bits read zero and writes are ignored.
module dma_ti_channel (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] peripheral_data_request,
  input  wire logic [31:0] peripheral_panic,
  output logic [39:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  output logic [3:0]       arqos,
  input  wire logic [7:0]  rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready,
  output logic [39:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [3:0]       awqos,
  output logic [7:0]       wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic             irq
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic dma_ti_pkg::byte_addr_t step_addr(
    input dma_ti_pkg::byte_addr_t addr,
    input logic                   wrap,
    input logic [15:0]            stride
  );
    dma_ti_pkg::byte_addr_t inc;
    inc = wrap ? {{24{stride[15]}}, stride} : 40'h00_0000_0000;
    step_addr = addr + `ADDR_ONE + inc;
  endfunction

  function automatic logic pick_line(input logic [31:0] lines, input logic [4:0] sel);
    pick_line = (sel == 5'h00) ? 1'b1 : lines[sel];
  endfunction

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  dma_ti_pkg::chan_state_e state_reg;
  logic [31:0]             ti_reg;
  logic [31:0]             src_reg;
  logic [7:0]              src_hi_reg;
  logic [31:0]             dst_reg;
  logic [7:0]              dst_hi_reg;
  logic [31:0]             len_reg;
  logic [31:0]             stride_reg;
  logic [2:0]              status_reg;
  logic [2:0]              mask_reg;
  dma_ti_pkg::row_cnt_t    rd_x_reg;
  dma_ti_pkg::rows_t       rd_y_reg;
  logic                    rd_done_reg;
  dma_ti_pkg::row_cnt_t    wr_x_reg;
  dma_ti_pkg::rows_t       wr_y_reg;
  logic                    wr_done_reg;
  logic [3:0]              rd_out_reg;
  logic [3:0]              wr_out_reg;
  logic [7:0]              hold_reg;
  logic                    hold_full_reg;
  logic                    aw_pend_reg;
  logic                    w_pend_reg;

  logic       wr_en;
  logic       rd_setup;
  logic       addr_hit;
  logic [31:0] rd_mux;
  logic [4:0] periph;
  logic       peripheral_data_request_sel;
  logic [3:0] qos_sel;
  logic       running;
  logic       start;
  logic       ar_start;
  logic       ar_hs;
  logic       r_hs;
  logic       aw_start;
  logic       wr_beat_done;
  logic       b_hs;
  logic       rd_wrap;
  logic       wr_wrap;
  logic       finish;
  logic [15:0] src_stride;
  logic [15:0] dst_stride;
  dma_ti_pkg::row_cnt_t x_init;
  dma_ti_pkg::rows_t    y_init;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = penable;
  assign running  = (state_reg != dma_ti_pkg::ST_IDLE);

  always_comb
  begin
    addr_hit = 1'b1;
    rd_mux   = `RST_WORD;
    unique case (paddr)
      `OFS_TRANSFER_INFORMATION: rd_mux = ti_reg & `TI_IMPLEMENTED; // see [RULE_18]
      `OFS_SOURCE_ADDRESS_LOW:   rd_mux = src_reg; // see [RULE_15]
      `OFS_SOURCE_ADDRESS_HIGH:  rd_mux = {24'h00_0000, src_hi_reg};
      `OFS_DEST_ADDRESS_LOW:     rd_mux = dst_reg;
      `OFS_DEST_ADDRESS_HIGH:    rd_mux = {24'h00_0000, dst_hi_reg};
      `OFS_TRANSFER_LENGTH:      rd_mux = len_reg;
      `OFS_ROW_STRIDE:           rd_mux = stride_reg;
      `OFS_CHANNEL_CONTROL:      rd_mux = {31'h0000_0000, running};
      `OFS_INT_STATUS:           rd_mux = {29'h0000_0000, status_reg};
      `OFS_INT_MASK:             rd_mux = {29'h0000_0000, mask_reg};
      default:                   addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_hit;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      prdata <= `RST_WORD;
    else if (ce && rd_setup)
      prdata <= rd_mux;
  end

  // Configuration other than the interrupt mask is frozen while the channel runs
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ti_reg     <= `RST_WORD;
      len_reg    <= `RST_WORD;
      stride_reg <= `RST_WORD;
      mask_reg   <= `RST_IRQ;
    end
    else if (ce && wr_en)
    begin
      if (paddr == `OFS_TRANSFER_INFORMATION && !running)
        ti_reg <= pwdata & `TI_IMPLEMENTED; // see [RULE_18]
      if (paddr == `OFS_TRANSFER_LENGTH && !running)
        len_reg <= pwdata & `LEN_IMPLEMENTED;
      if (paddr == `OFS_ROW_STRIDE && !running)
        stride_reg <= pwdata;
      if (paddr == `OFS_INT_MASK)
        mask_reg <= pwdata[`IRQ_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Pacing and quality of service
  // ---------------------------------------------------------------
  assign periph   = ti_reg[`TI_PERIPH_MSB:`TI_PERIPH_LSB]; // see [RULE_01]
  assign peripheral_data_request_sel = pick_line(peripheral_data_request, periph); // see [RULE_04]
  assign qos_sel  = (periph != 5'h00 && peripheral_panic[periph])
                    ? `QOS_PANIC : `QOS_NORMAL; // see [RULE_03]
  assign src_stride = stride_reg[`STRIDE_SRC_MSB:0];
  assign dst_stride = stride_reg[31:`STRIDE_DST_LSB];

  // Linear mode uses the whole 30-bit length as one row
  assign x_init = ti_reg[`TI_TWO_DIM]
                  ? {14'h0000, len_reg[`LEN_X_MSB:0]}
                  : len_reg[`LEN_Y_MSB:0]; // see [RULE_09] [RULE_11]
  assign y_init = ti_reg[`TI_TWO_DIM] ? len_reg[`LEN_Y_MSB:`LEN_Y_LSB] : 14'h0000;

  // ---------------------------------------------------------------
  // Channel control
  // ---------------------------------------------------------------
  assign start  = wr_en && paddr == `OFS_CHANNEL_CONTROL && pwdata[`CTRL_ACTIVE] && !running;
  assign finish = (state_reg == dma_ti_pkg::ST_CLOSE) && wr_out_reg == `RST_CNT;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state_reg <= dma_ti_pkg::ST_IDLE;
    else if (ce)
    begin
      unique case (state_reg)
        dma_ti_pkg::ST_IDLE:
          if (start)
            state_reg <= dma_ti_pkg::ST_RUN;
        dma_ti_pkg::ST_RUN:
          if (wr_done_reg && !aw_pend_reg && !w_pend_reg)
            state_reg <= dma_ti_pkg::ST_CLOSE;
        dma_ti_pkg::ST_CLOSE:
          if (finish)
            state_reg <= dma_ti_pkg::ST_IDLE; // see [RULE_07]
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read side
  // ---------------------------------------------------------------
  assign ar_start = (state_reg == dma_ti_pkg::ST_RUN) && !rd_done_reg && !arvalid
                    && (!ti_reg[`TI_READ_GATE] || peripheral_data_request_sel) // see [RULE_02] [RULE_16]
                    && (ti_reg[`TI_READ_WAIT] ? rd_out_reg == `RST_CNT // see [RULE_05]
                                              : rd_out_reg < `MAX_READS_OUT); // see [RULE_06]
  assign ar_hs   = arvalid & arready;
  assign r_hs    = rvalid & rready;
  assign rready  = (state_reg == dma_ti_pkg::ST_RUN) && !hold_full_reg;
  assign rd_wrap = (rd_x_reg == 30'h0000_0001) && (rd_y_reg != 14'h0000);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      arvalid <= 1'b0;
      araddr  <= 40'h00_0000_0000;
      arqos   <= `QOS_NORMAL;
    end
    else if (ce)
    begin
      if (ar_start)
      begin
        arvalid <= 1'b1;
        araddr  <= {src_hi_reg, src_reg}; // see [RULE_14]
        arqos   <= qos_sel; // see [RULE_03]
      end
      else if (ar_hs)
        arvalid <= 1'b0;
    end
  end

  // Source address and row counters advance on each accepted read
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      src_reg     <= `RST_WORD;
      src_hi_reg  <= `RST_HIGH;
      rd_x_reg    <= 30'h0000_0000;
      rd_y_reg    <= 14'h0000;
      rd_done_reg <= 1'b1;
    end
    else if (ce)
    begin
      if (start)
      begin
        rd_x_reg    <= x_init;
        rd_y_reg    <= y_init;
        rd_done_reg <= (x_init == 30'h0000_0000);
      end
      else if (ar_hs)
      begin
        {src_hi_reg, src_reg} <= step_addr({src_hi_reg, src_reg},
                                           rd_wrap, src_stride); // see [RULE_10] [RULE_15] [RULE_17]
        if (rd_x_reg != 30'h0000_0001)
          rd_x_reg <= rd_x_reg - 30'h0000_0001;
        else if (rd_y_reg != 14'h0000)
        begin
          rd_x_reg <= x_init;
          rd_y_reg <= rd_y_reg - 14'h0001; // see [RULE_09]
        end
        else
          rd_done_reg <= 1'b1;
      end
      if (wr_en && !running && paddr == `OFS_SOURCE_ADDRESS_LOW)
        src_reg <= pwdata; // see [RULE_13]
      if (wr_en && !running && paddr == `OFS_SOURCE_ADDRESS_HIGH)
        src_hi_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rd_out_reg <= `RST_CNT;
    else if (ce && (ar_hs != r_hs))
      rd_out_reg <= ar_hs ? rd_out_reg + 4'h1 : rd_out_reg - 4'h1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      hold_reg      <= `RST_HIGH;
      hold_full_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (r_hs)
      begin
        hold_reg      <= rdata;
        hold_full_reg <= 1'b1;
      end
      else if (wr_beat_done)
        hold_full_reg <= 1'b0; // see [RULE_08]
    end
  end

  // ---------------------------------------------------------------
  // Write side
  // ---------------------------------------------------------------
  assign aw_start = (state_reg == dma_ti_pkg::ST_RUN) && hold_full_reg && !wr_done_reg
                    && !aw_pend_reg && !w_pend_reg
                    && (!ti_reg[`TI_WRITE_GATE] || peripheral_data_request_sel) // see [RULE_02] [RULE_16]
                    && (ti_reg[`TI_WRITE_WAIT] ? wr_out_reg == `RST_CNT // see [RULE_07]
                                               : wr_out_reg < `MAX_WRITES_OUT); // see [RULE_08]
  assign awvalid = aw_pend_reg;
  assign wvalid  = w_pend_reg;
  assign bready  = 1'b1;
  assign b_hs    = bvalid;
  assign wr_beat_done = (aw_pend_reg || w_pend_reg)
                        && (!aw_pend_reg || awready) && (!w_pend_reg || wready);
  assign wr_wrap = (wr_x_reg == 30'h0000_0001) && (wr_y_reg != 14'h0000);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      aw_pend_reg <= 1'b0;
      w_pend_reg  <= 1'b0;
      awaddr      <= 40'h00_0000_0000;
      awqos       <= `QOS_NORMAL;
      wdata       <= `RST_HIGH;
    end
    else if (ce)
    begin
      if (aw_start)
      begin
        aw_pend_reg <= 1'b1;
        w_pend_reg  <= 1'b1;
        awaddr      <= {dst_hi_reg, dst_reg};
        awqos       <= qos_sel; // see [RULE_03]
        wdata       <= hold_reg;
      end
      else
      begin
        if (awready)
          aw_pend_reg <= 1'b0;
        if (wready)
          w_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      dst_reg     <= `RST_WORD;
      dst_hi_reg  <= `RST_HIGH;
      wr_x_reg    <= 30'h0000_0000;
      wr_y_reg    <= 14'h0000;
      wr_done_reg <= 1'b1;
    end
    else if (ce)
    begin
      if (start)
      begin
        wr_x_reg    <= x_init;
        wr_y_reg    <= y_init;
        wr_done_reg <= (x_init == 30'h0000_0000);
      end
      else if (wr_beat_done)
      begin
        {dst_hi_reg, dst_reg} <= step_addr({dst_hi_reg, dst_reg},
                                           wr_wrap, dst_stride); // see [RULE_10] [RULE_17]
        if (wr_x_reg != 30'h0000_0001)
          wr_x_reg <= wr_x_reg - 30'h0000_0001;
        else if (wr_y_reg != 14'h0000)
        begin
          wr_x_reg <= x_init;
          wr_y_reg <= wr_y_reg - 14'h0001;
        end
        else
          wr_done_reg <= 1'b1;
      end
      if (wr_en && !running && paddr == `OFS_DEST_ADDRESS_LOW)
        dst_reg <= pwdata;
      if (wr_en && !running && paddr == `OFS_DEST_ADDRESS_HIGH)
        dst_hi_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      wr_out_reg <= `RST_CNT;
    else if (ce && (wr_beat_done != b_hs))
      wr_out_reg <= wr_beat_done ? wr_out_reg + 4'h1 : wr_out_reg - 4'h1;
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [2:0] status_set;
  assign status_set = {b_hs && bresp[1], r_hs && rresp[1],
                       finish && ti_reg[`TI_INT_ENABLE]}; // see [RULE_12]

  // A set in the same cycle as a clear wins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      status_reg <= `RST_IRQ;
    else if (ce)
      status_reg <= (status_reg & ~((wr_en && paddr == `OFS_INT_STATUS)
                                    ? pwdata[`IRQ_WIDTH-1:0] : `RST_IRQ)) | status_set;
  end

  assign irq = |(status_reg & mask_reg);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_dummy_request: assert property ( // see [RULE_04]
    @(posedge clock) disable iff (!rst_n)
    (periph == 5'h00) |-> peripheral_data_request_sel)
    else $error("dummy request not active");

  chk_panic_qos: assert property ( // see [RULE_03]
    @(posedge clock) disable iff (!rst_n)
    (ce && ar_start && periph != 5'h00 && peripheral_panic[periph])
    |=> (arqos == `QOS_PANIC && arvalid))
    else $error("panic did not raise read qos");

  chk_single_read: assert property ( // see [RULE_05]
    @(posedge clock) disable iff (!rst_n)
    (ti_reg[`TI_READ_WAIT] && rd_out_reg != `RST_CNT) |-> !ar_start)
    else $error("second read issued while waiting");

  chk_single_write: assert property ( // see [RULE_07]
    @(posedge clock) disable iff (!rst_n)
    (ti_reg[`TI_WRITE_WAIT] && wr_out_reg != `RST_CNT) |-> !aw_start)
    else $error("second write issued while waiting");

  chk_read_gating: assert property ( // see [RULE_16]
    @(posedge clock) disable iff (!rst_n)
    (ti_reg[`TI_READ_GATE] && !peripheral_data_request_sel) |-> !ar_start)
    else $error("read issued while request low");

  chk_no_irq: assert property ( // see [RULE_12]
    @(posedge clock) disable iff (!rst_n)
    (ce && finish && !ti_reg[`TI_INT_ENABLE] && !status_reg[`IRQ_DONE])
    |=> !status_reg[`IRQ_DONE])
    else $error("completion flagged with interrupt disabled");

  chk_src_advance: assert property ( // see [RULE_15]
    @(posedge clock) disable iff (!rst_n)
    (ce && ar_hs && !rd_wrap && !start)
    |=> {src_hi_reg, src_reg} == $past({src_hi_reg, src_reg}) + `ADDR_ONE)
    else $error("source address did not step by one byte");

  chk_row_stride: assert property ( // see [RULE_17]
    @(posedge clock) disable iff (!rst_n)
    (ce && ar_hs && rd_wrap)
    |=> {src_hi_reg, src_reg} == $past({src_hi_reg, src_reg}) + `ADDR_ONE
        + {{24{$past(src_stride[15])}}, $past(src_stride)})
    else $error("row stride not applied");

  chk_reserved_zero: assert property ( // see [RULE_18]
    @(posedge clock) disable iff (!rst_n)
    (ti_reg & ~`TI_IMPLEMENTED) == `RST_WORD)
    else $error("reserved bits set");

  cov_two_dim_done: cover property (
    @(posedge clock) disable iff (!rst_n) finish && ti_reg[`TI_TWO_DIM]);
  cov_panic_read: cover property (
    @(posedge clock) disable iff (!rst_n) ar_hs && arqos == `QOS_PANIC);
  cov_gated_stall: cover property (
    @(posedge clock) disable iff (!rst_n)
    running && ti_reg[`TI_WRITE_GATE] && hold_full_reg && !peripheral_data_request_sel);
  cov_queued_reads: cover property (
    @(posedge clock) disable iff (!rst_n) rd_out_reg > 4'h1);

endmodule // dma_ti_channel

// >>> dv/axi_mem.sv
`timescale 1ns/1ps
// ---------------------------------
// Byte memory with paced answers
// ---------------------------------
module axi_mem (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic [39:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [7:0]       rdata,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [39:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  wdata,
  input  wire logic        wvalid,
  output logic             wready,
  output logic             bvalid,
  input  wire logic        bready
);
  logic [39:0] rq[$];
  logic [47:0] wlog[$];
  logic [2:0]  cnt;
  int          nb;
  int          max_rd;
  int          max_b;
  assign arready = !slow || cnt[0];
  assign awready = arready && awvalid && wvalid;
  assign wready  = awready;
  always @(posedge clock)
  begin
    cnt <= cnt + 3'd1;
    if (arvalid && arready) rq.push_back(araddr);
    if (rvalid && rready) void'(rq.pop_front());
    if (awvalid && awready) wlog.push_back({wdata, awaddr});
    nb = nb + (awvalid && awready) - (bvalid && bready);
    max_rd = rq.size() > max_rd ? rq.size() : max_rd;
    max_b  = nb > max_b ? nb : max_b;
    // Idle read data is inverted so a stale byte never looks valid
    if (!rvalid || rready)
    begin
      rvalid <= rq.size() > 0 && (!slow || cnt[1:0] == 2'd2);
      rdata  <= rq.size() > 0 ? rq[0][7:0] ^ 8'h5a : ~rdata;
    end
    if (!bvalid || bready) bvalid <= nb > 0 && (!slow || cnt == 3'd6);
    if (!rst_n)
    begin
      rq.delete();
      nb = 0;
      cnt    <= 3'd0;
      rvalid <= 1'b0;
      bvalid <= 1'b0;
      rdata  <= 8'h00;
    end
  end
endmodule // axi_mem

// >>> dv/dma_transfer_info_and_source_address_tb.sv
`timescale 1ns/1ps
`include "dma_ti_defines.svh"
module dma_transfer_info_and_source_address_tb;
  logic        clock = 1'b0, rst_n = 1'b0, ce = 1'b1, slow = 1'b0, req_on = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [4:0]  sel = 5'h00;
  logic [1:0]  ok = 2'b00;
  logic [31:0] pwdata = 32'h0000_0000, req = 32'h0000_0000, pan = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic [39:0] araddr, awaddr;
  logic [7:0]  rdata, wdata;
  logic [3:0]  arqos, qos_seen, awqos, wqos_seen;
  logic        pready, pslverr, er, irq, arvalid, arready, rvalid, rready, stuck;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  int          num_errors = 0, n_tests = 0, seed = 32'h0000_d687, k;

  always #2.5 clock = ~clock;
  // Selected line low and all others high while held back
  always @(posedge clock) req <= req_on ? $random(seed) | 32'h0000_0001 << sel : ~(32'h0000_0001 << sel);
  always @(posedge clock) if (arvalid && arready) qos_seen <= arqos;
  always @(posedge clock) if (awvalid && awready) wqos_seen <= awqos;

  dma_ti_channel DUT (.clock(clock), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .peripheral_data_request(req), .peripheral_panic(pan),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .arqos(arqos), .rdata(rdata),
    .rresp(ok), .rvalid(rvalid), .rready(rready), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .awqos(awqos), .wdata(wdata), .wvalid(wvalid), .wready(wready),
    .bresp(ok), .bvalid(bvalid), .bready(bready), .irq(irq));
  axi_mem mem (.clock(clock), .rst_n(rst_n), .slow(slow), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready));

  task check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && i++ < 50) @(posedge clock);
    if (pready !== 1'b1) num_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [39:0] ea(logic [31:0] b, int i, int x, logic two, logic [15:0] st);
    int off;
    off = two ? (i / x) * (x + $signed(st)) + i % x : i;
    return {8'h00, b} + 40'(off);
  endfunction

  task run(input logic [31:0] ti, len, st, input int n, x, input logic hold);
    logic [31:0] src, dst;
    logic [39:0] s;
    logic [3:0]  q;
    int i;
    src = $random(seed) & 32'h0FFF_FFFF | 32'h1000_0001;
    dst = $random(seed) & 32'h0FFF_FFFF | 32'h1000_0000;
    sel <= ti[13:9];
    req_on <= ti[13:9] != 5'h00 && !hold;
    mem.wlog.delete();
    mem.max_rd = 0;
    mem.max_b = 0;
    apb(1'b1, `OFS_SOURCE_ADDRESS_LOW, src);
    apb(1'b0, `OFS_SOURCE_ADDRESS_LOW, 32'h0000_0000);
    check(rd, src);
    apb(1'b1, `OFS_DEST_ADDRESS_LOW, dst);
    apb(1'b1, `OFS_TRANSFER_LENGTH, len);
    apb(1'b1, `OFS_ROW_STRIDE, st);
    apb(1'b1, `OFS_INT_MASK, 32'h0000_0001);
    apb(1'b1, `OFS_TRANSFER_INFORMATION, ti);
    apb(1'b1, `OFS_CHANNEL_CONTROL, 32'h0000_0001);
    if (hold)
    begin
      stuck = 1'b0;
      repeat (20)
      begin
        @(posedge clock);
        stuck = stuck | arvalid;
      end
      check(stuck, 1'b0);
      req_on <= 1'b1;
    end
    i = 0;
    do apb(1'b0, `OFS_CHANNEL_CONTROL, 32'h0000_0000);
    while (rd[0] !== 1'b0 && i++ < 400);
    if (rd[0] !== 1'b0) num_errors++;
    check(mem.wlog.size(), n);
    for (i = 0; i < n; i++)
    begin
      s = ea(src, i, x, ti[1], st[15:0]);
      check(mem.wlog[i], {s[7:0] ^ 8'h5a, ea(dst, i, x, ti[1], st[31:16])});
    end
    q = ti[13:9] != 5'h00 && pan[ti[13:9]] ? `QOS_PANIC : `QOS_NORMAL;
    check({wqos_seen, qos_seen}, {q, q});
    check(irq, ti[0]);
    apb(1'b0, `OFS_INT_STATUS, 32'h0000_0000);
    check(rd, {29'h0000_0000, ok[1], ok[1], ti[0]});
    apb(1'b1, `OFS_INT_STATUS, 32'h0000_0007);
    @(posedge clock);
    check(irq, 1'b0);
    apb(1'b0, `OFS_SOURCE_ADDRESS_LOW, 32'h0000_0000);
    check(rd, ea(src, n - 1, x, ti[1], st[15:0]) + 40'h00_0000_0001);
  endtask

  task end_sim;
    $display("Errors %0d Checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `OFS_SOURCE_ADDRESS_LOW, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b1, `OFS_TRANSFER_INFORMATION, 32'hFFFF_FFFF);
    apb(1'b0, `OFS_TRANSFER_INFORMATION, 32'h0000_0000);
    check(rd, 32'h0000_FE0F);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    check({er, rd}, 33'h1_0000_0000);
    ce <= 1'b0;
    apb(1'b1, `OFS_INT_MASK, 32'h0000_0007);
    ce <= 1'b1;
    apb(1'b0, `OFS_INT_MASK, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    k = 1 + $unsigned($random(seed)) % 31;
    slow <= 1'b1;
    pan <= 32'hFFFF_FFFE;
    run(32'h0000_C001, 32'h0000_0007, $random(seed), 7, 7, 1'b0);
    check(mem.max_rd > 1, 1'b1);
    run(32'h0000_000F, 32'h0002_0003, 32'h0004_FFFB, 9, 3, 1'b0);
    check(mem.max_rd, 1);
    check(mem.max_b, 1);
    slow <= 1'b0;
    pan <= 32'h0000_0001 << k;
    ok <= 2'b10;
    run(32'h0000_4000 | k << 9, 32'h0000_0006, 32'h0000_0000, 6, 6, 1'b1);
    ok <= 2'b00;
    slow <= 1'b1;
    pan <= 32'h0000_0000;
    run(32'h0000_8003 | k << 9, 32'h0001_0004, $random(seed), 8, 4, 1'b0);
    check(mem.max_b > 1, 1'b1);
    end_sim;
  end

  initial
  begin
    #300000;
    num_errors++;
    end_sim;
  end
endmodule // dma_transfer_info_and_source_address_tb
